// ===== common/gpio_pkg.sv
// shared constants and types for the six-bank gpio block
// assumes a 32-bit apb slave port and 48 pins, eight per bank
package gpio_pkg;

   localparam int NUM_BANKS = 6;
   localparam int PINS_PER_BANK = 8;
   localparam int NUM_PINS = 48;
   localparam int APB_AW = 8;
   localparam int NUM_INT_GROUPS = 3;

   // bank numbers follow address order
   localparam int BANK_A = 0;
   localparam int BANK_C = 1;
   localparam int BANK_B = 2;
   localparam int BANK_E = 3;
   localparam int BANK_D = 4;
   localparam int BANK_F = 5;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PORT_A_DATA = 8'h00;
   localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h01;
   localparam logic [7:0] IDX_PORT_A_OPTION = 8'h02;
   localparam logic [7:0] IDX_PORT_C_DATA = 8'h04;
   localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h05;
   localparam logic [7:0] IDX_PORT_C_OPTION = 8'h06;
   localparam logic [7:0] IDX_PORT_B_DATA = 8'h08;
   localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h09;
   localparam logic [7:0] IDX_PORT_B_OPTION = 8'h0A;
   localparam logic [7:0] IDX_PORT_E_DATA = 8'h0C;
   localparam logic [7:0] IDX_PORT_E_DIRECTION = 8'h0D;
   localparam logic [7:0] IDX_PORT_E_OPTION = 8'h0E;
   localparam logic [7:0] IDX_PORT_D_DATA = 8'h10;
   localparam logic [7:0] IDX_PORT_D_DIRECTION = 8'h11;
   localparam logic [7:0] IDX_PORT_D_OPTION = 8'h12;
   localparam logic [7:0] IDX_PORT_F_DATA = 8'h14;
   localparam logic [7:0] IDX_PORT_F_DIRECTION = 8'h15;
   localparam logic [7:0] IDX_PORT_F_OPTION = 8'h16;

   localparam logic [5:0][7:0] DATA_IDX = {IDX_PORT_F_DATA, IDX_PORT_D_DATA, IDX_PORT_E_DATA,
                                           IDX_PORT_B_DATA, IDX_PORT_C_DATA, IDX_PORT_A_DATA};
   localparam logic [5:0][7:0] DIR_IDX = {IDX_PORT_F_DIRECTION, IDX_PORT_D_DIRECTION, IDX_PORT_E_DIRECTION,
                                          IDX_PORT_B_DIRECTION, IDX_PORT_C_DIRECTION, IDX_PORT_A_DIRECTION};
   localparam logic [5:0][7:0] OPT_IDX = {IDX_PORT_F_OPTION, IDX_PORT_D_OPTION, IDX_PORT_E_OPTION,
                                          IDX_PORT_B_OPTION, IDX_PORT_C_OPTION, IDX_PORT_A_OPTION};

   // per bank masks, bank f in the top byte
   localparam logic [5:0][7:0] BONDED_MASK = {8'hD7, 8'h3F, 8'h03, 8'h1F, 8'hFF, 8'hF8};
   localparam logic [5:0][7:0] INT_CAP_MASK = {8'h07, 8'h00, 8'h00, 8'h1F, 8'h00, 8'h08};
   localparam logic [5:0][7:0] TRUE_OD_MASK = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF0};

   // pins sharing one interrupt line: a pin three, f low pins, b pins zero to four
   localparam logic [2:0][47:0] INT_GROUP_MASK = {48'h0000_001F_0000, 48'h0700_0000_0000, 48'h0000_0000_0008};

   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] OPT_RST = 8'h00;

   typedef enum logic [1:0] {
      SEL_DATA = 2'b00,
      SEL_DIR = 2'b01,
      SEL_OPT = 2'b10
   } reg_kind_t;

   typedef struct packed {
      logic hit;
      logic [2:0] bank;
      reg_kind_t kind;
   } dec_t;

   typedef struct packed {
      logic [47:0] drive_val;
      logic [47:0] oe_b;
      logic [47:0] pull_up;
   } pad_ctrl_t;

   typedef struct packed {
      logic [5:0][7:0] latch_bits;
      logic [5:0][7:0] direction_bits;
      logic [5:0][7:0] option_bits;
      logic ready;
      logic slverr;
      logic [7:0] rdata;
      pad_ctrl_t pad;
      logic [2:0] int_level;
   } gpio_state_t;

   typedef struct packed {
      logic [47:0] stage1;
      logic [47:0] stage2;
   } sync_state_t;

endpackage

// ===== logic/gpio_ports.sv
// six eight-bit bidirectional ports with apb register access
// assumes an apb master on mclk_i, pads that resolve drive/oe_b/pull_up,
// and an external edge/level detector on ext_int_level_o
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - direction bit set means output, clear input
// - data read gives latch for outputs, pin for inputs
// - data writes always update the latch
// - input option: clear floating, set pull-up
// - output option: clear open drain, set push-pull
// - interrupt pull-up only on listed pins
// - port a pins four-seven true open drain
// - unbonded pin bits forced to one
// - data and direction reset to zero
// - pad controls follow the selected mode
// - registers at fixed consecutive addresses per port
// - grouped interrupt pins are anded together
// - output pins generate no interrupt
// - peripheral output overrides the data latch
module gpio_ports
   import gpio_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // pads
   input wire logic [47:0] pin_level_i,
   output pad_ctrl_t pad_o,
   // on-chip peripheral alternate functions
   input wire logic [47:0] alt_en_i,
   input wire logic [47:0] alt_out_i,
   input wire logic [47:0] alt_pp_i,
   // to the external interrupt detector
   output logic [2:0] ext_int_level_o
);

   gpio_state_t state_reg;
   gpio_state_t state_next;
   logic [47:0] pin_synced;
   logic [47:0] int_en;
   logic [47:0] out_mode;
   dec_t dec;

   pin_sync u_pin_sync (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .level_i(pin_level_i),
      .sync_o(pin_synced)
   );

   function automatic dec_t decode(input logic [7:0] addr);
      dec_t d;
      d = '0;
      d.kind = SEL_DATA;
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (addr == {DATA_IDX[b][5:0], 2'b00}) begin
            d.hit = 1'b1;
            d.bank = 3'(b);
            d.kind = SEL_DATA;
         end
         if (addr == {DIR_IDX[b][5:0], 2'b00}) begin
            d.hit = 1'b1;
            d.bank = 3'(b);
            d.kind = SEL_DIR;
         end
         if (addr == {OPT_IDX[b][5:0], 2'b00}) begin
            d.hit = 1'b1;
            d.bank = 3'(b);
            d.kind = SEL_OPT;
         end
      end
      return d;
   endfunction

   assign dec = decode(paddr_i);

   always_comb begin
      logic [47:0] dir_f;
      logic [47:0] opt_f;
      logic [47:0] latch_f;
      logic [47:0] bond_f;
      logic [47:0] cap_f;
      logic [47:0] tod_f;
      logic [7:0] rd;
      logic [7:0] wmask;
      logic val;
      logic pp;
      logic drive;
      dir_f = state_reg.direction_bits;
      opt_f = state_reg.option_bits;
      latch_f = state_reg.latch_bits;
      bond_f = BONDED_MASK;
      cap_f = INT_CAP_MASK;
      tod_f = TRUE_OD_MASK;
      rd = '0;
      wmask = '0;
      val = 1'b0;
      pp = 1'b0;
      drive = 1'b0;
      state_next = state_reg;
      out_mode = '0;
      int_en = '0;

      // one wait state: answer in the cycle after the first access cycle
      state_next.ready = 1'b0;
      if (psel_i && penable_i && !state_reg.ready) begin
         state_next.ready = 1'b1;
         state_next.slverr = !dec.hit;
         unique case (dec.kind)
            SEL_DATA: begin
               // outputs read back the latch, inputs the synchronised pin
               rd = (state_reg.direction_bits[dec.bank] & state_reg.latch_bits[dec.bank]) |
                    (~state_reg.direction_bits[dec.bank] & pin_synced[dec.bank*8 +: 8]);
            end
            SEL_DIR: rd = state_reg.direction_bits[dec.bank];
            SEL_OPT: rd = state_reg.option_bits[dec.bank];
            default: rd = '0;
         endcase
         state_next.rdata = dec.hit ? (rd | ~BONDED_MASK[dec.bank]) : 8'h00;
      end

      // write lands at the edge where the master sees pready
      if (psel_i && penable_i && state_reg.ready && pwrite_i && dec.hit && pstrb_i[0]) begin
         wmask = pwdata_i[7:0];
         unique case (dec.kind)
            SEL_DATA: state_next.latch_bits[dec.bank] = wmask;
            SEL_DIR: state_next.direction_bits[dec.bank] = wmask;
            SEL_OPT: state_next.option_bits[dec.bank] = wmask;
            default: state_next.latch_bits[dec.bank] = state_reg.latch_bits[dec.bank];
         endcase
      end

      // unbonded bits stick at one whatever is written
      for (int b = 0; b < NUM_BANKS; b++) begin
         state_next.latch_bits[b] = state_next.latch_bits[b] | ~BONDED_MASK[b];
         state_next.direction_bits[b] = state_next.direction_bits[b] | ~BONDED_MASK[b];
         state_next.option_bits[b] = state_next.option_bits[b] | ~BONDED_MASK[b];
      end

      for (int i = 0; i < NUM_PINS; i++) begin
         // peripheral drive forces output mode and its own driver type
         out_mode[i] = bond_f[i] & (alt_en_i[i] | dir_f[i]);
         val = alt_en_i[i] ? alt_out_i[i] : latch_f[i];
         pp = (alt_en_i[i] ? alt_pp_i[i] : opt_f[i]) & !tod_f[i];
         drive = out_mode[i] & (pp | !val);
         state_next.pad.oe_b[i] = !drive;
         state_next.pad.drive_val[i] = drive & val;
         // no pull-up on true open drain pins
         state_next.pad.pull_up[i] = !out_mode[i] & opt_f[i] & bond_f[i] & !tod_f[i];
         int_en[i] = !out_mode[i] & !dir_f[i] & opt_f[i] & cap_f[i];
      end

      // disabled pins count as high so they never mask the others
      for (int g = 0; g < NUM_INT_GROUPS; g++) begin
         state_next.int_level[g] = &(~(INT_GROUP_MASK[g] & int_en) | pin_synced);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int b = 0; b < NUM_BANKS; b++) begin
            state_reg.latch_bits[b] <= DATA_RST | ~BONDED_MASK[b];
            state_reg.direction_bits[b] <= DIR_RST | ~BONDED_MASK[b];
            state_reg.option_bits[b] <= OPT_RST | ~BONDED_MASK[b];
         end
         state_reg.ready <= 1'b0;
         state_reg.slverr <= 1'b0;
         state_reg.rdata <= '0;
         state_reg.pad.drive_val <= '0;
         state_reg.pad.oe_b <= '1;
         state_reg.pad.pull_up <= '0;
         state_reg.int_level <= '1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata_o = {{24{1'b0}}, state_reg.rdata};
   assign pready_o = state_reg.ready;
   assign pslverr_o = state_reg.slverr;
   assign pad_o = state_reg.pad;
   assign ext_int_level_o = state_reg.int_level;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);

   property p_ready_pulse;
      psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready not a one-cycle answer");

   property p_read_latch;
      psel_i && penable_i && pready_o && !pwrite_i && paddr_i == {IDX_PORT_C_DATA[5:0], 2'b00} &&
         state_reg.direction_bits[BANK_C] == 8'hFF |-> prdata_o[7:0] == state_reg.latch_bits[BANK_C];
   endproperty
   a_read_latch: assert property (p_read_latch) else $error("output data read not from latch");

   property p_write_input_latch;
      psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && paddr_i == {IDX_PORT_C_DATA[5:0], 2'b00}
         |=> state_reg.latch_bits[BANK_C] == $past(pwdata_i[7:0]);
   endproperty
   a_write_input_latch: assert property (p_write_input_latch) else $error("data write lost");

   property p_push_pull;
      state_reg.direction_bits[BANK_C][0] && state_reg.option_bits[BANK_C][0] && !alt_en_i[8]
         |=> !pad_o.oe_b[8] && pad_o.drive_val[8] == $past(state_reg.latch_bits[BANK_C][0]);
   endproperty
   a_push_pull: assert property (p_push_pull) else $error("push-pull pin not driven");

   property p_open_drain_high;
      state_reg.direction_bits[BANK_C][0] && !state_reg.option_bits[BANK_C][0] &&
         state_reg.latch_bits[BANK_C][0] && !alt_en_i[8] |=> pad_o.oe_b[8] && !pad_o.pull_up[8];
   endproperty
   a_open_drain_high: assert property (p_open_drain_high) else $error("open drain drove high");

   property p_pull_up_input;
      !state_reg.direction_bits[BANK_C][0] && state_reg.option_bits[BANK_C][0] && !alt_en_i[8]
         |=> pad_o.pull_up[8] && pad_o.oe_b[8];
   endproperty
   a_pull_up_input: assert property (p_pull_up_input) else $error("pull-up input wrong");

   property p_true_open_drain;
      pad_o.pull_up[7:4] == 4'h0 && (pad_o.drive_val[7:4] & ~pad_o.oe_b[7:4]) == 4'h0;
   endproperty
   a_true_open_drain: assert property (p_true_open_drain) else $error("high-sink pin pulled or driven high");

   property p_forced_bits;
      &(state_reg.direction_bits | BONDED_MASK) && &(state_reg.latch_bits | BONDED_MASK);
   endproperty
   a_forced_bits: assert property (p_forced_bits) else $error("unbonded bit not one");

   property p_output_no_int;
      state_reg.direction_bits[BANK_A][3] |=> ext_int_level_o[0];
   endproperty
   a_output_no_int: assert property (p_output_no_int) else $error("output pin reached interrupt line");

   property p_group_and;
      !ext_int_level_o[1] |-> $past(|(INT_GROUP_MASK[1] & int_en & ~pin_synced));
   endproperty
   a_group_and: assert property (p_group_and) else $error("interrupt low without enabled low pin");

   property p_alt_priority;
      alt_en_i[32] && alt_pp_i[32] |=> !pad_o.oe_b[32] && pad_o.drive_val[32] == $past(alt_out_i[32]);
   endproperty
   a_alt_priority: assert property (p_alt_priority) else $error("peripheral output not on pin");

   property p_ready_idle;
      !psel_i |=> !pready_o;
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("pready without a selected transfer");

   property p_unmapped_err;
      psel_i && penable_i && !pready_o && !dec.hit |=> pready_o && pslverr_o && prdata_o == 32'h0000_0000;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

   property p_mapped_ok;
      psel_i && penable_i && !pready_o && dec.hit |=> pready_o && !pslverr_o;
   endproperty
   a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access flagged as error");

   property p_read_pin;
      psel_i && penable_i && !pready_o && !pwrite_i && paddr_i == {IDX_PORT_C_DATA[5:0], 2'b00} &&
         state_reg.direction_bits[BANK_C] == 8'h00 |=> prdata_o[7:0] == $past(pin_synced[15:8]);
   endproperty
   a_read_pin: assert property (p_read_pin) else $error("input data read not from pin");

   property p_dir_write;
      psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && paddr_i == {IDX_PORT_C_DIRECTION[5:0], 2'b00}
         |=> state_reg.direction_bits[BANK_C] == $past(pwdata_i[7:0]);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write lost");

   property p_opt_write;
      psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && paddr_i == {IDX_PORT_C_OPTION[5:0], 2'b00}
         |=> state_reg.option_bits[BANK_C] == $past(pwdata_i[7:0]);
   endproperty
   a_opt_write: assert property (p_opt_write) else $error("option write lost");

   property p_floating_input;
      !state_reg.direction_bits[BANK_C][0] && !state_reg.option_bits[BANK_C][0] && !alt_en_i[8]
         |=> pad_o.oe_b[8] && !pad_o.pull_up[8];
   endproperty
   a_floating_input: assert property (p_floating_input) else $error("floating input pulled or driven");

   property p_int_gate;
      !ext_int_level_o[1]
         |-> $past(|(~state_reg.direction_bits[BANK_F][2:0] & state_reg.option_bits[BANK_F][2:0]));
   endproperty
   a_int_gate: assert property (p_int_gate) else $error("interrupt low with no pull-up input pin");

   property p_unbonded_idle;
      &(pad_o.oe_b | BONDED_MASK) && (pad_o.pull_up & ~BONDED_MASK) == 48'h0000_0000_0000;
   endproperty
   a_unbonded_idle: assert property (p_unbonded_idle) else $error("unbonded pin driven or pulled");

   property p_output_int_f;
      state_reg.direction_bits[BANK_F][0] && pin_synced[41] && pin_synced[42] |=> ext_int_level_o[1];
   endproperty
   a_output_int_f: assert property (p_output_int_f) else $error("output pin pulled interrupt line low");

   property p_alt_no_pull;
      alt_en_i[32] |=> !pad_o.pull_up[32];
   endproperty
   a_alt_no_pull: assert property (p_alt_no_pull) else $error("pull-up left on under peripheral drive");

   property p_latch_stable;
      !(psel_i && penable_i && pready_o && pwrite_i) |=> $stable(state_reg.latch_bits);
   endproperty
   a_latch_stable: assert property (p_latch_stable) else $error("latch changed without a write");

   property p_dir_stable;
      !(psel_i && penable_i && pready_o && pwrite_i) |=> $stable(state_reg.direction_bits);
   endproperty
   a_dir_stable: assert property (p_dir_stable) else $error("direction changed without a write");

   property p_opt_stable;
      !(psel_i && penable_i && pready_o && pwrite_i) |=> $stable(state_reg.option_bits);
   endproperty
   a_opt_stable: assert property (p_opt_stable) else $error("option changed without a write");

   property p_open_drain_low;
      state_reg.direction_bits[BANK_C][2] && !state_reg.option_bits[BANK_C][2] &&
         !state_reg.latch_bits[BANK_C][2] && !alt_en_i[10] |=> !pad_o.oe_b[10] && !pad_o.drive_val[10];
   endproperty
   a_open_drain_low: assert property (p_open_drain_low) else $error("open drain pin not pulled low");

   property p_group_low;
      |(INT_GROUP_MASK[1] & int_en & ~pin_synced) |=> !ext_int_level_o[1];
   endproperty
   a_group_low: assert property (p_group_low) else $error("enabled low pin did not pull line low");

endmodule

// ===== logic/pin_sync.sv
// two-flop synchroniser for the 48 pad input levels
// assumes pad levels are asynchronous to mclk_i
`timescale 1ns/1ps
module pin_sync
   import gpio_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // levels
   input wire logic [47:0] level_i,
   output logic [47:0] sync_o
);

   sync_state_t sync_reg;
   sync_state_t sync_next;

   // stage1 feeds stage2 only
   always_comb begin
      sync_next = sync_reg;
      sync_next.stage1 = level_i;
      sync_next.stage2 = sync_reg.stage1;
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_reg <= '1;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign sync_o = sync_reg.stage2;

endmodule

// ===== verif/gpio_ports_six_banks_bench.sv
// self-checking bench for gpio_ports: apb master, pin model, read checks from a queue
// assumes the design answers every access in bounded time; pstrb stays at byte 0
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module gpio_ports_six_banks_bench;
   import gpio_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [47:0] level;
   logic [47:0] ext_en = '0;
   logic [47:0] ext_val = '0;
   logic [47:0] alt_en = '0;
   logic [47:0] alt_out = '0;
   logic [47:0] alt_pp = '0;
   logic [2:0] int_lvl;
   pad_ctrl_t pad;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [31:0] seed = 32'h0000_E582;
   logic [7:0] w;
   int checks = 0;
   int miscompares = 0;

   always #2.5 mclk_i = ~mclk_i;

   gpio_ports u_gpio_ports (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'h1), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .pin_level_i(level), .pad_o(pad), .alt_en_i(alt_en),
      .alt_out_i(alt_out), .alt_pp_i(alt_pp), .ext_int_level_o(int_lvl));
   pin_model u_pin_model (.mclk_i(mclk_i), .pad_i(pad), .ext_en_i(ext_en), .ext_val_i(ext_val),
      .level_o(level));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge mclk_i);
      penable <= 1'b1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         wrap_up();
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic err);
      exp_q.push_back({err, 24'h00_0000, d});
      apb(1'b0, a, 8'h00);
   endtask

   // a write lands at the pready edge, pads follow one cycle later
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
      repeat (3) @(negedge mclk_i);
   endtask

   always @(posedge mclk_i) begin
      if (pready === 1'b1 && pwrite === 1'b0) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : 33'h1_FFFF_FFFF;
         `CHK("apb read", e, {pslverr, prdata})
      end
   end

   initial begin
      repeat (6) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      for (int b = 0; b < 6; b++) begin
         rd({DIR_IDX[b][5:0], 2'b00}, ~BONDED_MASK[b], 1'b0);
         rd({OPT_IDX[b][5:0], 2'b00}, ~BONDED_MASK[b], 1'b0);
      end
      rd(8'h0C, 8'h00, 1'b1);
      $display("done reset_map");
      seed = lfsr(seed);
      w = seed[15:8];
      ext_en <= 48'h0000_0000_FF00;
      ext_val <= {32'h0000_0000, seed[7:0], 8'h00};
      wr(8'h10, w);
      rd(8'h10, seed[7:0], 1'b0);
      wr(8'h14, 8'hFF);
      rd(8'h10, w, 1'b0);
      `CHK("od oe_b", w, pad.oe_b[15:8])
      `CHK("od pull", 8'h00, pad.pull_up[15:8])
      wr(8'h18, 8'hFF);
      `CHK("pp oe_b", 8'h00, pad.oe_b[15:8])
      `CHK("pp drive", w, pad.drive_val[15:8])
      wr(8'h14, 8'h00);
      `CHK("in pull", 8'hFF, pad.pull_up[15:8])
      $display("done port_c");
      // unbonded direction bits are always written as ones, their reset value
      wr(8'h00, 8'hF8);
      wr(8'h08, 8'hF8);
      wr(8'h04, 8'hFF);
      `CHK("a oe_b", 8'hF7, pad.oe_b[7:0])
      wr(8'h04, 8'h07);
      `CHK("a pull", 8'h08, pad.pull_up[7:0])
      $display("done port_a");
      ext_en <= 48'h0700_0000_0000;
      ext_val <= 48'h0500_0000_0000;
      wr(8'h58, 8'h07);
      `CHK("int and", 3'b101, int_lvl)
      ext_val <= 48'h0700_0000_0000;
      repeat (4) @(negedge mclk_i);
      `CHK("int high", 3'b111, int_lvl)
      ext_val <= 48'h0600_0000_0000;
      wr(8'h54, 8'h01);
      `CHK("int out", 3'b111, int_lvl)
      $display("done interrupts");
      // pin d0 is a floating input, never an interrupt input
      alt_en <= 48'h0001_0000_0000;
      alt_out <= 48'h0001_0000_0000;
      alt_pp <= 48'h0001_0000_0000;
      repeat (3) @(negedge mclk_i);
      `CHK("alt oe_b", 1'b0, pad.oe_b[32])
      `CHK("alt drive", 1'b1, pad.drive_val[32])
      $display("done alternate");
      `CHK("queue empty", 0, exp_q.size())
      wrap_up();
   end
endmodule

// ===== verif/pin_model.sv
// external pin model: resolves each pad wire from block drive, outside drive and pull-up
// assumes pad_ctrl_t from gpio_pkg and one clock; the block drive wins over the outside
`timescale 1ns/1ps
module pin_model
   import gpio_pkg::*;
(
   // clock
   input wire logic mclk_i,
   // pad controls and outside drivers
   input wire pad_ctrl_t pad_i,
   input wire logic [47:0] ext_en_i,
   input wire logic [47:0] ext_val_i,
   // resolved levels
   output logic [47:0] level_o
);
   logic [47:0] float_reg = '0;
   // undriven pins toggle every cycle so a stale level never passes
   always_ff @(posedge mclk_i) begin
      float_reg <= ~float_reg;
   end
   always_comb begin
      for (int i = 0; i < 48; i++) begin
         if (!pad_i.oe_b[i]) level_o[i] = pad_i.drive_val[i];
         else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
         else if (pad_i.pull_up[i]) level_o[i] = 1'b1;
         else level_o[i] = float_reg[i];
      end
   end
endmodule
